// ==== nip_irq_ctrl.sv ====
// Nested interrupt priority controller with external sensitivity and register slave.
//
// Behaviour
// - Four 8-bit priority registers, reset all ones.
// - Fourth register upper nibble read-only ones.
// - Vector n uses register n/4 pair n mod 4.
// - Servicing loads vector pair into core priority.
// - Encodings 10=L0, 01=L1, 00=L2, 11=L3.
// - Writing level-0 pattern keeps that pair unchanged.
// - Reset and trap set level 3.
// - Raised priority of pending running vector re-enters.
// - Enable/halt/wait load 10; disable loads 11.
// - Instruction-set priority persists until next change.
// - Popped condition code restores priority bits.
// - Branch flags for masked and not masked.
// - Fixed vector assignment, hardware order by number.
// - Halt wake capability per source.
// - Four external groups; groups 0/1 share one sensitivity code and groups 2/3 the other.
// - Fall, rise, both, fall+low; rise+high groups 0,2.
// - Sensitivity writable only at level 3.
// - Changed sensitivity clears pending external requests.
// - Sense code per group pair; polarity inversion for groups 0 and 2 only.
// - Edge request latched, cleared on service entry.
// - Highest software level first, ties by number.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module nip_irq_ctrl
  import nip_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire nip_core_cmd_t             coreCmd,
  input  wire logic [NIP_NUM_VEC-1:0]    periphReq,
  input  wire nip_ext_pins_t             extPins,
  output nip_core_stat_t                 coreStat
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Maps a priority pair to a numeric level so that bigger means more urgent.
  function automatic logic [1:0] prioLevel(input logic [1:0] pair);
    logic [1:0] lvl;
    lvl = 2'h0;
    case (pair)
      NIP_LVL0: lvl = 2'h0;
      NIP_LVL1: lvl = 2'h1;
      NIP_LVL2: lvl = 2'h2;
      NIP_LVL3: lvl = 2'h3;
      default:  lvl = 2'h0;
    endcase
    return lvl;
  endfunction : prioLevel

  // External group of each synchronous pin, index order as in nip_ext_pins_t.
  function automatic int pinGroup(input int pin);
    int grp;
    grp = 3;
    if (pin < 4) begin
      grp = 0;
    end else if (pin < 7) begin
      grp = 1;
    end else if (pin < 11) begin
      grp = 2;
    end
    return grp;
  endfunction : pinGroup

  // Merges a written priority byte, keeping any pair written as level 0.
  function automatic logic [7:0] prioMerge(input logic [7:0] oldVal, input logic [7:0] wr);
    logic [7:0] res;
    res = oldVal;
    for (int p = 0; p < 4; p++) begin
      if (wr[2*p +: 2] != NIP_LVL0) begin
        res[2*p +: 2] = wr[2*p +: 2];
      end
    end
    return res;
  endfunction : prioMerge

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0][7:0]          prio;
    logic [7:0]               sense;
    logic [NIP_NUM_PINS-1:0]  pinPrev;
    logic [3:0]               edgeLatch;
    logic [1:0]               curPrio;
    nip_core_stat_t           stat;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } nip_state_t;

  // All state sits in one register so reset and update stay in one place.
  // The bus handshake, the latches and the core status share that register,
  // which keeps every output a plain flip-flop with no logic after it.
  nip_state_t stateFf;
  nip_state_t nxtState;

  // ****************************************************************
  // External pin sensing
  // ****************************************************************
  logic [NIP_NUM_PINS-1:0] pinNow;
  logic [NIP_NUM_PINS-1:0] pinEdgeHit;
  logic [NIP_NUM_PINS-1:0] pinLevelHit;
  logic [3:0]              grpEdge;
  logic [3:0]              grpLevel;

  assign pinNow = extPins;

  genvar gi;
  generate
    for (gi = 0; gi < NIP_NUM_PINS; gi++) begin : g_pin
      localparam int GRP = pinGroup(gi);
      logic [1:0] code;
      logic       inv;
      logic       rise;
      logic       fall;
      // Groups 0/1 share one code field, groups 2/3 the other.
      assign code = (GRP < 2) ? stateFf.sense[NIP_SENSE_G01_POS +: 2]
                              : stateFf.sense[NIP_SENSE_G23_POS +: 2];
      // Polarity only exists for the lower four pins of ports A and B.
      assign inv  = (GRP == 0) ? stateFf.sense[NIP_SENSE_PA_POS]
                  : (GRP == 2) ? stateFf.sense[NIP_SENSE_PB_POS] : 1'b0;
      assign rise = ~stateFf.pinPrev[gi] & pinNow[gi];
      assign fall = stateFf.pinPrev[gi] & ~pinNow[gi];
      always_comb begin
        pinEdgeHit[gi]  = 1'b0;
        pinLevelHit[gi] = 1'b0;
        case (code)
          NIP_SNS_FALL_LOW: begin
            pinEdgeHit[gi]  = inv ? rise : fall;
            pinLevelHit[gi] = inv ? pinNow[gi] : ~pinNow[gi];
          end
          NIP_SNS_RISE: pinEdgeHit[gi] = inv ? fall : rise;
          NIP_SNS_FALL: pinEdgeHit[gi] = inv ? rise : fall;
          NIP_SNS_BOTH: pinEdgeHit[gi] = rise | fall;
          default:      pinEdgeHit[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Pins of a group are ORed onto its one vector.
  assign grpEdge[0]  = |pinEdgeHit[3:0];

  assign grpEdge[1]  = |pinEdgeHit[6:4];

  assign grpEdge[2]  = |pinEdgeHit[10:7];

  assign grpEdge[3]  = |pinEdgeHit[14:11];

  // Level hits are not latched, so a pin released early keeps its request only through its edge latch.
  assign grpLevel[0] = |pinLevelHit[3:0];

  assign grpLevel[1] = |pinLevelHit[6:4];

  assign grpLevel[2] = |pinLevelHit[10:7];

  assign grpLevel[3] = |pinLevelHit[14:11];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // The request seen by the core is one cycle behind the pending set.
  // An edge therefore takes two cycles to reach the core: one to latch
  // and one to arbitrate.
  // The core must only acknowledge while a request is shown.
  // The acknowledge uses the vector registered with that request, so
  // a newer winner in the same cycle cannot be entered by mistake.
  // Trading one cycle of latency for this keeps the arbiter off the
  // critical path into the core.
  always_comb begin
    logic [31:0]            prioFlat;
    logic [NIP_NUM_VEC-1:0] pending;
    logic [3:0]             bestVec;
    logic [1:0]             bestLvl;
    logic                   found;
    logic                   wrFire;
    logic                   rdFire;
    logic [7:0]             wrByte;
    logic [7:0]             newSense;
    logic                   senseChanged;
    logic [3:0]             latchClr;
    logic [31:0]            rdVal;
    logic                   rdOk;
    logic [1:0]             cur;

    nxtState     = stateFf;
    prioFlat     = stateFf.prio;
    bestVec      = 4'h0;
    bestLvl      = 2'h0;
    found        = 1'b0;
    wrByte       = s_axi_wdata[7:0];
    newSense     = stateFf.sense;
    senseChanged = 1'b0;
    latchClr     = 4'h0;
    rdVal        = 32'h0;
    rdOk         = 1'b1;
    cur          = stateFf.curPrio;

    // ---- Register bus: one write and one read in flight at a time.
    wrFire = stateFf.awready & s_axi_awvalid & stateFf.wready & s_axi_wvalid;
    rdFire = stateFf.arready & s_axi_arvalid;
    nxtState.awready = 1'b0;
    nxtState.wready  = 1'b0;
    nxtState.arready = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !stateFf.awready && !stateFf.bvalid) begin
      nxtState.awready = 1'b1;
      nxtState.wready  = 1'b1;
    end
    if (s_axi_arvalid && !stateFf.arready && !stateFf.rvalid) begin
      nxtState.arready = 1'b1;
    end
    if (stateFf.bvalid && s_axi_bready) begin
      nxtState.bvalid = 1'b0;
    end
    if (stateFf.rvalid && s_axi_rready) begin
      nxtState.rvalid = 1'b0;
    end

    if (wrFire) begin
      nxtState.bvalid = 1'b1;
      nxtState.bresp  = NIP_RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        case (s_axi_awaddr)
          NIP_OFS_PRIO0: nxtState.prio[0] = prioMerge(stateFf.prio[0], wrByte);
          NIP_OFS_PRIO1: nxtState.prio[1] = prioMerge(stateFf.prio[1], wrByte);
          NIP_OFS_PRIO2: nxtState.prio[2] = prioMerge(stateFf.prio[2], wrByte);
          NIP_OFS_PRIO3: begin
            nxtState.prio[3] = prioMerge(stateFf.prio[3], wrByte) | NIP_PRIO3_FIXED;
          end
          NIP_OFS_SENSE: begin
            // Writes are dropped unless the core sits at level 3.
            if (stateFf.curPrio == NIP_LVL3) begin
              newSense     = wrByte & NIP_SENSE_WMASK;
              senseChanged = (newSense != stateFf.sense);
              nxtState.sense = newSense;
            end
          end
          NIP_OFS_STATUS: ;
          default: nxtState.bresp = NIP_RESP_SLVERR;
        endcase
      end
    end

    if (rdFire) begin
      case (s_axi_araddr)
        NIP_OFS_PRIO0:  rdVal[7:0] = stateFf.prio[0];
        NIP_OFS_PRIO1:  rdVal[7:0] = stateFf.prio[1];
        NIP_OFS_PRIO2:  rdVal[7:0] = stateFf.prio[2];
        NIP_OFS_PRIO3:  rdVal[7:0] = stateFf.prio[3] | NIP_PRIO3_FIXED;
        NIP_OFS_SENSE:  rdVal[7:0] = stateFf.sense;
        NIP_OFS_STATUS: rdVal = {20'h0, stateFf.edgeLatch, stateFf.stat.irqVec,
                                 1'b0, stateFf.stat.irqReq, stateFf.curPrio};
        default:        rdOk = 1'b0;
      endcase
      nxtState.rvalid = 1'b1;
      nxtState.rdata  = rdVal;
      nxtState.rresp  = rdOk ? NIP_RESP_OKAY : NIP_RESP_SLVERR;
    end

    // ---- Core priority bits. Trap wins, then service entry, then instructions.
    if (coreCmd.trapStb) begin
      cur = NIP_LVL3;
    end else if (coreCmd.serviceAck) begin
      cur = prioFlat[2*stateFf.stat.irqVec +: 2];
      if (stateFf.stat.irqVec >= 4'(NIP_VEC_EXT0) && stateFf.stat.irqVec < 4'(NIP_VEC_EXT0 + 4)) begin
        latchClr[2'(stateFf.stat.irqVec - 4'(NIP_VEC_EXT0))] = 1'b1;
      end
    end else if (coreCmd.returnStb || coreCmd.popCcStb) begin
      cur = {coreCmd.poppedCc[NIP_CC_HIGH_POS], coreCmd.poppedCc[NIP_CC_LOW_POS]};
    end else if (coreCmd.disableStb) begin
      cur = NIP_LVL3;
    end else if (coreCmd.enableStb || coreCmd.haltStb || coreCmd.waitStb) begin
      cur = NIP_LVL0;
    end
    nxtState.curPrio = cur;

    // ---- Edge latches: a new edge in the clearing cycle survives.
    if (senseChanged) begin
      latchClr = 4'hf;
    end
    nxtState.edgeLatch = (stateFf.edgeLatch & ~latchClr) | grpEdge;
    nxtState.pinPrev   = pinNow;

    // ---- Arbitration over the fixed vector map.
    pending = (periphReq & NIP_USED_MASK & ~NIP_EXT_MASK)
            | ({8'h0, stateFf.edgeLatch | grpLevel, 2'h0} & NIP_EXT_MASK);
    for (int v = 0; v < NIP_NUM_VEC; v++) begin
      // Strict compare keeps the lower number on a tie.
      if (pending[v] && (!found || prioLevel(prioFlat[2*v +: 2]) > bestLvl)) begin
        found   = 1'b1;
        bestVec = 4'(v);
        bestLvl = prioLevel(prioFlat[2*v +: 2]);
      end
    end
    // A running vector whose pair was raised compares above its own level again.
    nxtState.stat.irqReq = found && (bestLvl > prioLevel(cur)) && !coreCmd.serviceAck;
    nxtState.stat.irqVec = bestVec;

    nxtState.stat.curPrioHigh       = cur[1];
    nxtState.stat.curPrioLow        = cur[0];
    nxtState.stat.branchIfMasked    = (cur == NIP_LVL3);
    nxtState.stat.branchIfNotMasked = (cur != NIP_LVL3);
    nxtState.stat.wakeFullHalt      = |(pending & NIP_FULL_WAKE);
    nxtState.stat.wakeActiveHalt    = |(pending & NIP_ACTIVE_WAKE);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateFf                        <= '0;
      stateFf.prio                   <= {4{NIP_PRIO_RESET}};
      stateFf.sense                  <= NIP_SENSE_RESET;
      stateFf.pinPrev                <= '1;
      stateFf.curPrio                <= NIP_LVL3;
      stateFf.stat.curPrioHigh       <= 1'b1;
      stateFf.stat.curPrioLow        <= 1'b1;
      stateFf.stat.branchIfMasked    <= 1'b1;
    end else begin
      stateFf <= nxtState;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = stateFf.awready;

  assign s_axi_wready  = stateFf.wready;

  assign s_axi_bvalid  = stateFf.bvalid;

  assign s_axi_bresp   = stateFf.bresp;

  assign s_axi_arready = stateFf.arready;

  assign s_axi_rvalid  = stateFf.rvalid;

  assign s_axi_rdata   = stateFf.rdata;

  assign s_axi_rresp   = stateFf.rresp;

  assign coreStat      = stateFf.stat;

endmodule : nip_irq_ctrl

// ==== nip_pkg.sv ====
// Shared constants and carrier types for the nested interrupt priority block.
package nip_pkg;

  // ****************************************************************
  // Register map (byte addresses on the register bus)
  // ****************************************************************
  localparam logic [7:0] NIP_OFS_PRIO0  = 8'h00;
  localparam logic [7:0] NIP_OFS_PRIO1  = 8'h04;
  localparam logic [7:0] NIP_OFS_PRIO2  = 8'h08;
  localparam logic [7:0] NIP_OFS_PRIO3  = 8'h0c;
  localparam logic [7:0] NIP_OFS_SENSE  = 8'h10;
  localparam logic [7:0] NIP_OFS_STATUS = 8'h14;

  localparam logic [7:0] NIP_PRIO_RESET  = 8'hff;
  localparam logic [7:0] NIP_PRIO3_FIXED = 8'hf0;
  localparam logic [7:0] NIP_SENSE_RESET = 8'h00;
  localparam logic [7:0] NIP_SENSE_WMASK = 8'hfc;

  // Sense register fields.
  localparam int NIP_SENSE_G23_POS = 6;
  localparam int NIP_SENSE_PB_POS  = 5;
  localparam int NIP_SENSE_G01_POS = 3;
  localparam int NIP_SENSE_PA_POS  = 2;

  // ****************************************************************
  // Priority encodings (high bit, low bit)
  // ****************************************************************
  localparam logic [1:0] NIP_LVL0 = 2'h2;
  localparam logic [1:0] NIP_LVL1 = 2'h1;
  localparam logic [1:0] NIP_LVL2 = 2'h0;
  localparam logic [1:0] NIP_LVL3 = 2'h3;
  localparam int NIP_CC_HIGH_POS = 5;
  localparam int NIP_CC_LOW_POS  = 3;

  // Sensitivity codes.
  localparam logic [1:0] NIP_SNS_FALL_LOW = 2'h0;
  localparam logic [1:0] NIP_SNS_RISE     = 2'h1;
  localparam logic [1:0] NIP_SNS_FALL     = 2'h2;
  localparam logic [1:0] NIP_SNS_BOTH     = 2'h3;

  // ****************************************************************
  // Vector map
  // ****************************************************************
  localparam int NIP_NUM_VEC = 14;
  localparam logic [13:0] NIP_USED_MASK   = 14'h07be;
  localparam logic [13:0] NIP_EXT_MASK    = 14'h003c;
  localparam logic [13:0] NIP_FULL_WAKE   = 14'h00be;
  localparam logic [13:0] NIP_ACTIVE_WAKE = 14'h0002;
  localparam int NIP_VEC_EXT0 = 2;
  localparam int NIP_NUM_PINS = 15;

  localparam logic [1:0] NIP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] NIP_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic       enableStb;
    logic       disableStb;
    logic       haltStb;
    logic       waitStb;
    logic       popCcStb;
    logic       returnStb;
    logic [7:0] poppedCc;
    logic       trapStb;
    logic       serviceAck;
  } nip_core_cmd_t;

  typedef struct packed {
    logic [3:0] portBHigh;
    logic [3:0] portBLow;
    logic [2:0] portFLow;
    logic [3:0] portALow;
  } nip_ext_pins_t;

  typedef struct packed {
    logic       irqReq;
    logic [3:0] irqVec;
    logic       curPrioHigh;
    logic       curPrioLow;
    logic       branchIfMasked;
    logic       branchIfNotMasked;
    logic       wakeFullHalt;
    logic       wakeActiveHalt;
  } nip_core_stat_t;

endpackage : nip_pkg

// ==== nip_irq_ctrl_props.sv ====
// Concurrent property checker for the nested interrupt priority controller.
`timescale 1ns/1ps

module nip_irq_ctrl_props
  import nip_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           reset_n,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  input wire nip_core_cmd_t  coreCmd,
  input wire nip_core_stat_t coreStat
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic [1:0] popPrio_ff;
  logic [1:0] cur;
  logic       hiCmd;
  assign cur   = {coreStat.curPrioHigh, coreStat.curPrioLow};
  assign hiCmd = coreCmd.trapStb | coreCmd.serviceAck | coreCmd.returnStb | coreCmd.popCcStb;

  // Holds the popped priority pair so the restore can be compared one cycle later.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      popPrio_ff <= 2'h0;
    end else begin
      popPrio_ff <= {coreCmd.poppedCc[5], coreCmd.poppedCc[3]};
    end
  end

  a_disable_mask: assert property (coreCmd.disableStb && !hiCmd |=> cur == NIP_LVL3)
    else $error("disable did not mask");
  a_enable_open: assert property ((coreCmd.enableStb || coreCmd.haltStb || coreCmd.waitStb)
    && !hiCmd && !coreCmd.disableStb |=> cur == NIP_LVL0)
    else $error("enable did not open level 0");
  a_trap_level: assert property (coreCmd.trapStb |=> cur == NIP_LVL3)
    else $error("trap did not set level 3");
  a_pop_restore: assert property ((coreCmd.returnStb || coreCmd.popCcStb) && !coreCmd.trapStb
    && !coreCmd.serviceAck |=> cur == popPrio_ff)
    else $error("popped priority not restored");
  a_branch_flags: assert property (coreStat.branchIfMasked == (cur == NIP_LVL3)
    && coreStat.branchIfNotMasked == !coreStat.branchIfMasked)
    else $error("branch flags disagree with level");
  a_ack_clears: assert property (coreCmd.serviceAck |=> !coreStat.irqReq)
    else $error("request stayed after entry");
  a_unused_quiet: assert property (coreStat.irqReq |-> !(coreStat.irqVec inside {4'h0, 4'h6,
    4'hb, 4'hc, 4'hd}))
    else $error("unused vector requested");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:3] s_axi_arready)
    else $error("read address not taken");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready not a pulse");
endmodule : nip_irq_ctrl_props

bind nip_irq_ctrl nip_irq_ctrl_props u_props (.sys_clk, .reset_n, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .coreCmd, .coreStat);

// ==== nip_core_model.sv ====
// Core-side model that enters offered vectors after a chosen delay.
`timescale 1ns/1ps

module nip_core_model
  import nip_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           reset_n,
  input  wire nip_core_cmd_t  tbCmd,
  input  wire nip_core_stat_t coreStat,
  input  wire logic           ackEn,
  input  wire logic [3:0]     ackDelay,
  output nip_core_cmd_t       coreCmd
);
  logic [3:0] wait_ff;
  logic       ack_ff;

  // The core only enters a vector that is still offered; a late entry would be a phantom one.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 4'h0;
      ack_ff  <= 1'b0;
    end else begin
      ack_ff  <= coreStat.irqReq && ackEn && !ack_ff && wait_ff == ackDelay;
      wait_ff <= (coreStat.irqReq && !ack_ff) ? wait_ff + 4'h1 : 4'h0;
    end
  end

  always_comb begin
    coreCmd            = tbCmd;
    coreCmd.serviceAck = ack_ff;
  end
endmodule : nip_core_model

// ==== testbench.sv ====
// Self-checking testbench for the nested interrupt priority controller.
`timescale 1ns/1ps

module testbench;
  import nip_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } nip_row_t;

  logic             sys_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic             s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  nip_core_cmd_t    tbCmd = '0, coreCmd, c;
  nip_core_stat_t   coreStat;
  logic [13:0]      periphReq = 14'h0;
  nip_ext_pins_t    extPins = '1;
  logic             ackEn = 1'b0;
  logic [3:0]       ackDelay = 4'h2;
  logic [31:0]      rd;
  int               num_errors = 0;
  int               tests_run = 0;
  nip_row_t rows[10] = '{'{1'b0, 8'h00, 8'h00, 8'hff, NIP_RESP_OKAY},
    '{1'b0, 8'h0c, 8'h00, 8'hff, NIP_RESP_OKAY}, '{1'b1, 8'h00, 8'hcf, 8'hcf, NIP_RESP_OKAY},
    '{1'b1, 8'h00, 8'h64, 8'h44, NIP_RESP_OKAY}, '{1'b1, 8'h0c, 8'h00, 8'hf0, NIP_RESP_OKAY},
    '{1'b1, 8'h10, 8'hff, 8'hfc, NIP_RESP_OKAY}, '{1'b1, 8'h10, 8'h00, 8'h00, NIP_RESP_OKAY},
    '{1'b0, 8'h18, 8'h00, 8'h00, NIP_RESP_SLVERR}, '{1'b1, 8'h08, 8'h55, 8'h55, NIP_RESP_OKAY},
    '{1'b0, 8'h14, 8'h00, 8'h03, NIP_RESP_OKAY}};

  nip_irq_ctrl DUT (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coreCmd, .periphReq,
    .extPins, .coreStat);
  nip_core_model u_core (.sys_clk, .reset_n, .tbCmd, .coreStat, .ackEn, .ackDelay, .coreCmd);

  always #20 sys_clk = ~sys_clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic strobe(input nip_core_cmd_t s);
    @(posedge sys_clk);
    tbCmd <= s;
    @(posedge sys_clk);
    tbCmd <= '0;
    @(negedge sys_clk);
  endtask : strobe

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle

  task automatic chk_lvl(input logic [1:0] e);
    chk("level", {30'h0, e}, {30'h0, coreStat.curPrioHigh, coreStat.curPrioLow});
  endtask : chk_lvl

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d);
      axi_rd(rows[i].a);
      chk("reg data", {24'h0, rows[i].e}, rd);
      chk("reg resp", {30'h0, rows[i].r}, {30'h0, resp});
    end
    $display("Test registers done");
    // Bits 15..12 of the command are enable, disable, halt and wait in that order.
    for (int k = 0; k < 4; k++) begin
      strobe(nip_core_cmd_t'(16'h4000));
      strobe(nip_core_cmd_t'(16'h8000 >> k));
      chk_lvl(k == 1 ? NIP_LVL3 : NIP_LVL0);
      chk("masked flag", {31'h0, k == 1}, {31'h0, coreStat.branchIfMasked});
    end
    $display("Test instructions done");
    @(posedge sys_clk);
    periphReq <= 14'h0300;
    idle(4);
    chk("tie vector", 32'h8, {28'h0, coreStat.irqVec});
    ackEn <= 1'b1;
    idle(24);
    chk_lvl(NIP_LVL1);
    @(posedge sys_clk);
    periphReq <= 14'h0200;
    axi_wr(8'h08, 8'h51);
    idle(24);
    chk_lvl(NIP_LVL2);
    @(posedge sys_clk);
    periphReq <= 14'h0;
    c = '0;
    c.returnStb = 1'b1;
    c.poppedCc = 8'h20;
    strobe(c);
    chk_lvl(NIP_LVL0);
    $display("Test nesting done");
    @(posedge sys_clk);
    periphReq <= 14'h0841;
    idle(6);
    chk("unused req", 32'h0, {31'h0, coreStat.irqReq});
    $display("Test unused done");
    @(posedge sys_clk);
    periphReq <= 14'h0;
    ackEn <= 1'b0;
    extPins.portALow <= 4'he;
    idle(6);
    chk("low level req", 32'h2, {28'h0, coreStat.irqVec});
    chk("wake", 32'h2, {30'h0, coreStat.wakeFullHalt, coreStat.wakeActiveHalt});
    @(posedge sys_clk);
    extPins.portALow <= 4'hf;
    idle(4);
    chk("edge latched", 32'h1, {31'h0, coreStat.irqReq});
    ackEn <= 1'b1;
    idle(24);
    chk_lvl(NIP_LVL2);
    chk("latch cleared", 32'h0, {31'h0, coreStat.irqReq});
    strobe(c);
    axi_wr(8'h10, 8'h18);
    chk("write resp", {30'h0, NIP_RESP_OKAY}, {30'h0, resp});
    axi_rd(8'h10);
    chk("sense locked", 32'h0, rd);
    $display("Test external done");
    strobe(nip_core_cmd_t'(16'h4000));
    @(posedge sys_clk);
    extPins.portALow <= 4'he;
    idle(4);
    axi_wr(8'h10, 8'h10);
    strobe(nip_core_cmd_t'(16'h8000));
    idle(6);
    chk("pending cleared", 32'h0, {31'h0, coreStat.irqReq});
    @(posedge sys_clk);
    extPins.portALow <= 4'hf;
    $display("Test sense change done");
    c = '0;
    c.trapStb = 1'b1;
    strobe(c);
    chk_lvl(NIP_LVL3);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_rd(8'h08);
    chk("prio after reset", 32'hff, rd);
    chk_lvl(NIP_LVL3);
    $display("Test trap and reset done");
    give_verdict();
  end
endmodule : testbench
